// *** rtl/system_power_state_control.sv ***
// System power state controller: state machine, gating and power outputs.
//
// Summary of operation
// RULE_01: First sleep state only while every core reports sleep or deeper.
// RULE_02: First sleep: memories retained, NVM standby, fast RC on, core clocks gated.
// RULE_03: Second sleep state additionally needs every peripheral to report idle.
// RULE_04: Second sleep: memories retained, NVM standby, fast RC on, all clocks gated.
// RULE_05: Deep sleep 0: selected SRAM and cache retained, NVM off, CPU domains off.
// RULE_06: Deep sleep 1 equals deep sleep 0 but cache is powered off.
// RULE_07: Deep sleep 2: minimal SRAM, fast RC off, crystal on, switched domains off.
// RULE_08: Software asks for deep sleep 2 only with peripherals idle or saved.
// RULE_09: Deep sleep 3: no memory, slow RC only, logic retained, one timer runs.
// RULE_10: NVM off when all CPU requesters off and DMA requesters off or sleeping.
// RULE_11: Retained TCM selectable: none, 32, 96, 128, 256, 352, 384 kB.
// RULE_12: Domain power gate asserted on requested off, forced off, deep sleep 2 and 3 and oscillator wake, else powered.
// RULE_13: Encoded machine enters deepest met and permitted state, wakes to active.
// RULE_14: On deep wake restore oscillators, power, memory before core clocks.
`timescale 1ns/1ps
module system_power_state_control #(
   parameter int NCPU = 1,
   parameter int NDMA = 2,
   parameter int NPER = 8,
   parameter int NDOM = 4,
   parameter int OSC_CYC = pwr_pkg::OSC_SETTLE_CYC,
   parameter int PWR_CYC = pwr_pkg::PWR_SETTLE_CYC,
   parameter int MEM_CYC = pwr_pkg::MEM_SETTLE_CYC
) (
   // Clock, reset and enable
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Requesters and wake, asynchronous
   input wire logic [2*NCPU-1:0] cpu_lvl_i,
   input wire logic [2*NDMA-1:0] dma_lvl_i,
   input wire logic [2*NDOM-1:0] dom_lvl_i,
   input wire logic [NPER-1:0] periph_idle_i,
   input wire logic wakeup_i,
   // Clocks and oscillators
   output logic core_clk_en_o,
   output logic periph_clk_en_o,
   output logic high_freq_rc_oscillator_en_o,
   output logic low_freq_rc_oscillator_en_o,
   output logic xtal_en_o,
   output logic timer_run_o,
   // Power domains
   output logic cpu_dom_pwr_o,
   output logic cpu_state_retain_o,
   output logic [NDOM-1:0] dom_pg_o,
   // Memories
   output logic nvm_pwr_off_o,
   output logic nvm_standby_o,
   output logic cache_pwr_off_o,
   output logic cache_retain_o,
   output logic [pwr_pkg::TCM_BANKS-1:0] tcm_pwr_o,
   output logic [pwr_pkg::SSRAM_HALVES-1:0] ssram_pwr_o,
   // State
   output logic [3:0] sys_state_o
);

   // ------------------------------------------------------------------
   // Per-state control vector
   // ------------------------------------------------------------------
   function automatic logic [pwr_pkg::C_W-1:0] ctl_of(input pwr_pkg::sys_state_t st);
      logic [pwr_pkg::C_W-1:0] c;
      c = '0;
      // The always-on clock and its timer keep running in every state.
      c[pwr_pkg::C_LOW_FREQ_RC_OSCILLATOR] = 1'b1;
      c[pwr_pkg::C_TIMER] = 1'b1;
      case (st)
         pwr_pkg::ST_ACT: begin
            c[pwr_pkg::C_NVM_ON:pwr_pkg::C_CORE_CLK] = '1;
            c[pwr_pkg::C_CACHE_ON] = 1'b1;
            c[pwr_pkg::C_MEM_ALL] = 1'b1;
         end
         pwr_pkg::ST_S0, pwr_pkg::ST_S1: begin
            c[pwr_pkg::C_PER_CLK] = (st == pwr_pkg::ST_S0); // RULE_02 RULE_04
            c[pwr_pkg::C_HIGH_FREQ_RC_OSCILLATOR] = 1'b1;
            c[pwr_pkg::C_MEM_ALL:pwr_pkg::C_XTAL] = '1;
         end
         pwr_pkg::ST_DS0, pwr_pkg::ST_DS1: begin
            c[pwr_pkg::C_HIGH_FREQ_RC_OSCILLATOR:pwr_pkg::C_PER_CLK] = '1;
            c[pwr_pkg::C_XTAL] = 1'b1;
            c[pwr_pkg::C_PER_PWR] = 1'b1;
            c[pwr_pkg::C_CACHE_ON] = (st == pwr_pkg::ST_DS0); // RULE_05 RULE_06
            c[pwr_pkg::C_CACHE_RET] = (st == pwr_pkg::ST_DS0); // RULE_06
            c[pwr_pkg::C_MEM_SEL] = 1'b1;
            c[pwr_pkg::C_RETAIN] = 1'b1;
         end
         pwr_pkg::ST_DS2: begin
            c[pwr_pkg::C_XTAL] = 1'b1; // RULE_07
            c[pwr_pkg::C_MEM_SEL] = 1'b1;
            c[pwr_pkg::C_RETAIN] = 1'b1;
         end
         pwr_pkg::ST_DS3: begin
            c[pwr_pkg::C_RETAIN] = 1'b1; // RULE_09
         end
         pwr_pkg::ST_WK_OSC: begin
            c[pwr_pkg::C_HIGH_FREQ_RC_OSCILLATOR] = 1'b1; // RULE_14
            c[pwr_pkg::C_XTAL] = 1'b1;
            c[pwr_pkg::C_MEM_SEL] = 1'b1;
            c[pwr_pkg::C_RETAIN] = 1'b1;
         end
         pwr_pkg::ST_WK_PWR: begin
            c[pwr_pkg::C_HIGH_FREQ_RC_OSCILLATOR] = 1'b1;
            c[pwr_pkg::C_PER_PWR:pwr_pkg::C_XTAL] = '1; // RULE_14
            c[pwr_pkg::C_MEM_SEL] = 1'b1;
            c[pwr_pkg::C_RETAIN] = 1'b1;
         end
         pwr_pkg::ST_WK_MEM: begin
            c[pwr_pkg::C_HIGH_FREQ_RC_OSCILLATOR] = 1'b1;
            c[pwr_pkg::C_NVM_ON:pwr_pkg::C_XTAL] = '1; // RULE_14
            c[pwr_pkg::C_CACHE_ON] = 1'b1;
            c[pwr_pkg::C_MEM_ALL] = 1'b1;
            c[pwr_pkg::C_RETAIN] = 1'b1;
         end
         default: c = '0;
      endcase
      return c;
   endfunction

   localparam logic [pwr_pkg::C_W-1:0] CTL_RST = ctl_of(pwr_pkg::ST_ACT);
   localparam int SW = 2 * NCPU + 2 * NDMA + 2 * NDOM + NPER + 1;

   // ------------------------------------------------------------------
   // Input synchronisation
   // ------------------------------------------------------------------
   logic [SW-1:0] sync_q;
   logic [2*NCPU-1:0] cpu_lvl;
   logic [2*NDMA-1:0] dma_lvl;
   logic [2*NDOM-1:0] dom_lvl;
   logic [NPER-1:0] per_idle_v;
   logic wake_s;

   // The synchroniser resets to zero, so levels pass it inverted: after reset every
   // requester reads active and wake high, never off, so no false sleep follows reset.
   sync2 #(.W(SW)) u_sync (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .ce_i(ce_i),
      .d_i(~{cpu_lvl_i, dma_lvl_i, dom_lvl_i, periph_idle_i, wakeup_i}),
      .q_o(sync_q)
   );

   assign {cpu_lvl, dma_lvl, dom_lvl, per_idle_v, wake_s} = ~sync_q;

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   logic [3:0] max_depth;
   logic [2:0] tcm_sel;
   logic [1:0] ssram_sel;
   logic [NDOM-1:0] force_off;
   logic [31:0] status;

   power_regs #(.NDOM(NDOM)) u_regs (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .ce_i(ce_i),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i),
      .wb_sel_i(wb_sel_i),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .status_i(status),
      .max_depth_o(max_depth),
      .tcm_sel_o(tcm_sel),
      .ssram_sel_o(ssram_sel),
      .force_off_o(force_off)
   );

   // ------------------------------------------------------------------
   // Entry conditions
   // ------------------------------------------------------------------
   logic cpus_sleep;
   logic cpus_deep;
   logic cpus_off;
   logic dma_quiet;
   logic [NDOM-1:0] dom_off_req;

   always_comb begin
      cpus_sleep = 1'b1;
      cpus_deep = 1'b1;
      cpus_off = 1'b1;
      dma_quiet = 1'b1;
      for (int i = 0; i < NCPU; i++) begin
         cpus_sleep &= cpu_lvl[2*i +: 2] != pwr_pkg::LVL_ACT;
         cpus_deep &= cpu_lvl[2*i +: 2] <= pwr_pkg::LVL_DEEP;
         cpus_off &= cpu_lvl[2*i +: 2] == pwr_pkg::LVL_OFF;
      end
      for (int i = 0; i < NDMA; i++) begin
         dma_quiet &= (dma_lvl[2*i +: 2] == pwr_pkg::LVL_OFF) |
                      (dma_lvl[2*i +: 2] == pwr_pkg::LVL_SLEEP);
      end
      for (int i = 0; i < NDOM; i++) begin
         dom_off_req[i] = dom_lvl[2*i +: 2] == pwr_pkg::LVL_OFF;
      end
   end

   wire per_idle = &per_idle_v;
   wire nvm_req_off = cpus_off & dma_quiet; // RULE_10
   // Hardware ceiling: deep codes need deep cores, sleep codes need sleeping cores.
   wire [3:0] hw_cap = cpus_deep ? pwr_pkg::DEPTH_DEEPEST :
                       cpus_sleep ? 4'(pwr_pkg::ST_S1) : 4'(pwr_pkg::ST_ACT); // RULE_01
   wire [3:0] sw_cap = (max_depth > pwr_pkg::DEPTH_DEEPEST) ? pwr_pkg::DEPTH_DEEPEST : max_depth;
   wire [3:0] tgt_raw = (sw_cap < hw_cap) ? sw_cap : hw_cap; // RULE_13
   // The second sleep state falls back to the first while a peripheral is busy.
   wire [3:0] target = (tgt_raw == 4'(pwr_pkg::ST_S1) && !per_idle) ?
                       4'(pwr_pkg::ST_S0) : tgt_raw; // RULE_03
   wire wake = wake_s | ~cpus_sleep;

   // ------------------------------------------------------------------
   // State machine
   // ------------------------------------------------------------------
   pwr_pkg::sys_state_t state_r, state_nxt;
   logic [pwr_pkg::CNT_W-1:0] cnt_r, cnt_nxt;

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
      case (state_r)
         pwr_pkg::ST_ACT: begin
            if (!wake && target != 4'(pwr_pkg::ST_ACT)) begin
               state_nxt = pwr_pkg::sys_state_t'(target); // RULE_13
            end
         end
         pwr_pkg::ST_S0, pwr_pkg::ST_S1: begin
            if (wake) begin
               state_nxt = pwr_pkg::ST_ACT;
            end
         end
         pwr_pkg::ST_DS0, pwr_pkg::ST_DS1, pwr_pkg::ST_DS2, pwr_pkg::ST_DS3: begin
            if (wake) begin
               state_nxt = pwr_pkg::ST_WK_OSC; // RULE_14
               cnt_nxt = pwr_pkg::CNT_W'(OSC_CYC - 1);
            end
         end
         pwr_pkg::ST_WK_OSC: begin
            if (cnt_r == '0) begin
               state_nxt = pwr_pkg::ST_WK_PWR;
               cnt_nxt = pwr_pkg::CNT_W'(PWR_CYC - 1);
            end
         end
         pwr_pkg::ST_WK_PWR: begin
            if (cnt_r == '0) begin
               state_nxt = pwr_pkg::ST_WK_MEM;
               cnt_nxt = pwr_pkg::CNT_W'(MEM_CYC - 1);
            end
         end
         pwr_pkg::ST_WK_MEM: begin
            if (cnt_r == '0) begin
               state_nxt = pwr_pkg::ST_ACT; // RULE_14
            end
         end
         default: state_nxt = pwr_pkg::ST_ACT;
      endcase
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_r <= pwr_pkg::ST_ACT;
         cnt_r <= '0;
      end else if (ce_i) begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Output decoding
   // ------------------------------------------------------------------
   logic [pwr_pkg::C_W-1:0] ctl_r;
   logic [NDOM-1:0] pg_r;
   logic nvm_off_r;
   logic [pwr_pkg::TCM_BANKS-1:0] tcm_r;
   logic [pwr_pkg::SSRAM_HALVES-1:0] ssram_r;
   logic [pwr_pkg::C_W-1:0] ctl_nxt;
   logic [pwr_pkg::TCM_BANKS-1:0] tcm_nxt;
   logic [pwr_pkg::SSRAM_HALVES-1:0] ssram_nxt;
   logic [pwr_pkg::SSRAM_HALVES-1:0] ssram_sel_mask;

   assign ctl_nxt = ctl_of(state_nxt);
   assign ssram_sel_mask = (ssram_sel == 2'h0) ? 2'h0 : (ssram_sel == 2'h1) ? 2'h1 : 2'h3;
   assign tcm_nxt = ctl_nxt[pwr_pkg::C_MEM_ALL] ? '1 :
                    ctl_nxt[pwr_pkg::C_MEM_SEL] ? pwr_pkg::tcm_mask(tcm_sel) : '0; // RULE_11
   // The shared SRAM is dropped in deep sleep 2 so only the selected TCM stays retained.
   assign ssram_nxt = ctl_nxt[pwr_pkg::C_MEM_ALL] ? '1 :
                      (ctl_nxt[pwr_pkg::C_MEM_SEL] && state_nxt != pwr_pkg::ST_DS2) ?
                      ssram_sel_mask : '0; // RULE_07

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ctl_r <= CTL_RST;
         pg_r <= '0;
         nvm_off_r <= 1'b0;
         tcm_r <= '1;
         ssram_r <= '1;
      end else if (ce_i) begin
         ctl_r <= ctl_nxt;
         pg_r <= dom_off_req | force_off | {NDOM{~ctl_nxt[pwr_pkg::C_PER_PWR]}}; // RULE_12
         nvm_off_r <= ~ctl_nxt[pwr_pkg::C_NVM_ON] | nvm_req_off; // RULE_10
         tcm_r <= tcm_nxt;
         ssram_r <= ssram_nxt;
      end
   end

   assign status = {24'h00_0000, nvm_off_r, per_idle, cpus_deep, cpus_sleep, state_r};

   assign core_clk_en_o = ctl_r[pwr_pkg::C_CORE_CLK];
   assign periph_clk_en_o = ctl_r[pwr_pkg::C_PER_CLK];
   assign high_freq_rc_oscillator_en_o = ctl_r[pwr_pkg::C_HIGH_FREQ_RC_OSCILLATOR];
   assign low_freq_rc_oscillator_en_o = ctl_r[pwr_pkg::C_LOW_FREQ_RC_OSCILLATOR];
   assign xtal_en_o = ctl_r[pwr_pkg::C_XTAL];
   assign timer_run_o = ctl_r[pwr_pkg::C_TIMER];
   assign cpu_dom_pwr_o = ctl_r[pwr_pkg::C_CPU_PWR];
   assign cpu_state_retain_o = ctl_r[pwr_pkg::C_RETAIN];
   assign dom_pg_o = pg_r;
   assign nvm_pwr_off_o = nvm_off_r;
   assign nvm_standby_o = ctl_r[pwr_pkg::C_NVM_STBY] & ~nvm_off_r;
   assign cache_pwr_off_o = ~ctl_r[pwr_pkg::C_CACHE_ON];
   assign cache_retain_o = ctl_r[pwr_pkg::C_CACHE_RET];
   assign tcm_pwr_o = tcm_r;
   assign ssram_pwr_o = ssram_r;
   assign sys_state_o = state_r;

endmodule

// *** rtl/pwr_pkg.sv ***
// Shared constants, types and TCM mask decoding for the system power state controller.
package pwr_pkg;

   // ------------------------------------------------------------------
   // System power states
   // ------------------------------------------------------------------
   // Codes 0 to 6 double as depth codes: a larger code is a deeper state.
   typedef enum logic [3:0] {
      ST_ACT    = 4'h0,
      ST_S0     = 4'h1,
      ST_S1     = 4'h2,
      ST_DS0    = 4'h3,
      ST_DS1    = 4'h4,
      ST_DS2    = 4'h5,
      ST_DS3    = 4'h6,
      ST_WK_OSC = 4'h7,
      ST_WK_PWR = 4'h8,
      ST_WK_MEM = 4'h9
   } sys_state_t;

   localparam logic [3:0] DEPTH_DEEPEST = 4'h6;

   // ------------------------------------------------------------------
   // Requester power levels, two bits per requester
   // ------------------------------------------------------------------
   localparam logic [1:0] LVL_OFF = 2'h0;
   localparam logic [1:0] LVL_DEEP = 2'h1;
   localparam logic [1:0] LVL_SLEEP = 2'h2;
   localparam logic [1:0] LVL_ACT = 2'h3;

   // ------------------------------------------------------------------
   // Register map, byte addresses on the Wishbone bus
   // ------------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_MEMRET = 8'h04;
   localparam logic [7:0] REG_FORCE = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;

   localparam int CTRL_DEPTH_LSB = 0;
   localparam int MEMRET_TCM_LSB = 0;
   localparam int MEMRET_SSRAM_LSB = 4;
   localparam logic [3:0] CTRL_DEPTH_RST = 4'h2;
   localparam logic [2:0] MEMRET_TCM_RST = 3'h6;
   localparam logic [1:0] MEMRET_SSRAM_RST = 2'h2;

   // ------------------------------------------------------------------
   // Memory geometry
   // ------------------------------------------------------------------
   localparam int TCM_BANKS = 12;
   localparam int SSRAM_HALVES = 2;

   // Retained TCM banks of 32 kB: none, 32, 96, 128, 256, 352, 384 kB.
   function automatic logic [TCM_BANKS-1:0] tcm_mask(input logic [2:0] sel);
      case (sel)
         3'h0: tcm_mask = 12'h000;
         3'h1: tcm_mask = 12'h001;
         3'h2: tcm_mask = 12'h007;
         3'h3: tcm_mask = 12'h00f;
         3'h4: tcm_mask = 12'h0ff;
         3'h5: tcm_mask = 12'h7ff;
         default: tcm_mask = 12'hfff;
      endcase
   endfunction

   // ------------------------------------------------------------------
   // Wake sequencing times
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 5000;
   localparam int OSC_SETTLE_NS = 2000;
   localparam int PWR_SETTLE_NS = 1000;
   localparam int MEM_SETTLE_NS = 500;
   localparam int OSC_SETTLE_CYC = (OSC_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int PWR_SETTLE_CYC = (PWR_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int MEM_SETTLE_CYC = (MEM_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W = 12;

   // ------------------------------------------------------------------
   // Control vector bit positions
   // ------------------------------------------------------------------
   localparam int C_CORE_CLK = 0;
   localparam int C_PER_CLK = 1;
   localparam int C_HIGH_FREQ_RC_OSCILLATOR = 2;
   localparam int C_LOW_FREQ_RC_OSCILLATOR = 3;
   localparam int C_XTAL = 4;
   localparam int C_CPU_PWR = 5;
   localparam int C_PER_PWR = 6;
   localparam int C_NVM_ON = 7;
   localparam int C_NVM_STBY = 8;
   localparam int C_CACHE_ON = 9;
   localparam int C_CACHE_RET = 10;
   localparam int C_MEM_ALL = 11;
   localparam int C_MEM_SEL = 12;
   localparam int C_TIMER = 13;
   localparam int C_RETAIN = 14;
   localparam int C_W = 15;

endpackage

// *** rtl/sync2.sv ***
// Two-flop synchroniser for a bundle of asynchronous level inputs.
`timescale 1ns/1ps
module sync2 #(
   parameter int W = 1
) (
   // Clock, reset and enable
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   // Levels
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         meta_r <= '0;
         q_r <= '0;
      end else if (ce_i) begin
         meta_r <= d_i;
         q_r <= meta_r;
      end
   end

   assign q_o = q_r;

endmodule

// *** rtl/power_regs.sv ***
// Wishbone classic register slave holding the power controller settings.
`timescale 1ns/1ps
module power_regs #(
   parameter int NDOM = 4
) (
   // Clock, reset and enable
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Settings and status
   input wire logic [31:0] status_i,
   output logic [3:0] max_depth_o,
   output logic [2:0] tcm_sel_o,
   output logic [1:0] ssram_sel_o,
   output logic [NDOM-1:0] force_off_o
);

   logic ack_r;
   logic [31:0] dat_r;
   logic [3:0] depth_r;
   logic [2:0] tcm_r;
   logic [1:0] ssram_r;
   logic [NDOM-1:0] force_r;
   logic [31:0] rd_mux;
   wire req = wb_cyc_i & wb_stb_i & ~ack_r;
   wire wr_lo = req & wb_we_i & wb_sel_i[0];
   wire sel_ctrl = wb_adr_i == pwr_pkg::REG_CTRL;
   wire sel_mem = wb_adr_i == pwr_pkg::REG_MEMRET;
   wire sel_force = wb_adr_i == pwr_pkg::REG_FORCE;
   wire sel_stat = wb_adr_i == pwr_pkg::REG_STATUS;

   // Unmapped addresses are acknowledged and read as zero.
   assign rd_mux = sel_ctrl ? 32'(depth_r) :
                   sel_mem ? 32'({ssram_r, 1'b0, tcm_r}) :
                   sel_force ? 32'(force_r) :
                   sel_stat ? status_i : 32'h0000_0000;

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ack_r <= 1'b0;
         dat_r <= 32'h0000_0000;
      end else if (ce_i) begin
         ack_r <= req;
         dat_r <= rd_mux;
      end
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         depth_r <= pwr_pkg::CTRL_DEPTH_RST;
         tcm_r <= pwr_pkg::MEMRET_TCM_RST;
         ssram_r <= pwr_pkg::MEMRET_SSRAM_RST;
         force_r <= '0;
      end else if (ce_i && wr_lo) begin
         if (sel_ctrl) begin
            depth_r <= wb_dat_i[pwr_pkg::CTRL_DEPTH_LSB +: 4];
         end
         if (sel_mem) begin
            tcm_r <= wb_dat_i[pwr_pkg::MEMRET_TCM_LSB +: 3];
            ssram_r <= wb_dat_i[pwr_pkg::MEMRET_SSRAM_LSB +: 2];
         end
         if (sel_force) begin
            force_r <= wb_dat_i[NDOM-1:0];
         end
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;
   assign max_depth_o = depth_r;
   assign tcm_sel_o = tcm_r;
   assign ssram_sel_o = ssram_r;
   assign force_off_o = force_r;

endmodule

// *** testbench/pwr_state_asserts.sv ***
// Concurrent checks on the outputs of the system power state controller.
`timescale 1ns/1ps
module pwr_state_asserts #(parameter int NDOM = 4) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic sys_rst_i,
   // Controller outputs
   input wire logic core_clk_en_o,
   input wire logic periph_clk_en_o,
   input wire logic high_freq_rc_oscillator_en_o,
   input wire logic xtal_en_o,
   input wire logic cpu_dom_pwr_o,
   input wire logic cpu_state_retain_o,
   input wire logic [NDOM-1:0] dom_pg_o,
   input wire logic nvm_pwr_off_o,
   input wire logic nvm_standby_o,
   input wire logic cache_retain_o,
   input wire logic [pwr_pkg::TCM_BANKS-1:0] tcm_pwr_o,
   input wire logic [3:0] sys_state_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   wire hf = high_freq_rc_oscillator_en_o;
   wire [3:0] st = sys_state_o;
   a_sleep0_gating: assert property (st == 4'h1 |->
      !core_clk_en_o && periph_clk_en_o && hf && nvm_standby_o) else $error("sleep 0 outputs");
   a_sleep1_gating: assert property (st == 4'h2 |->
      !core_clk_en_o && !periph_clk_en_o && hf && nvm_standby_o) else $error("sleep 1 outputs");
   a_deep0_power: assert property (st == 4'h3 |->
      cache_retain_o && nvm_pwr_off_o && !cpu_dom_pwr_o && hf) else $error("deep 0 outputs");
   a_deep1_power: assert property (st == 4'h4 |->
      !cache_retain_o && nvm_pwr_off_o && !cpu_dom_pwr_o && hf) else $error("deep 1 outputs");
   a_deep2_power: assert property (st == 4'h5 |-> !hf && xtal_en_o && &dom_pg_o &&
      cpu_state_retain_o && !cache_retain_o && nvm_pwr_off_o) else $error("deep 2 outputs");
   a_deep3_power: assert property (st == 4'h6 |-> tcm_pwr_o == '0 && !hf &&
      !xtal_en_o && cpu_state_retain_o && &dom_pg_o) else $error("deep 3 outputs");
   a_sleep_exit_wake: assert property ($changed(st) && $past(st) inside {[4'h1:4'h6]} |->
      st inside {4'h0, 4'h7}) else $error("sleep state left without waking");
   a_clk_after_mem: assert property ($rose(core_clk_en_o) |->
      $past(st) inside {4'h1, 4'h2, 4'h9}) else $error("core clock before restore");
endmodule
bind system_power_state_control pwr_state_asserts #(.NDOM(NDOM)) chk_u (.clock_i, .sys_rst_i,
   .core_clk_en_o, .periph_clk_en_o, .high_freq_rc_oscillator_en_o, .xtal_en_o, .cpu_dom_pwr_o,
   .cpu_state_retain_o, .dom_pg_o, .nvm_pwr_off_o, .nvm_standby_o, .cache_retain_o, .tcm_pwr_o,
   .sys_state_o);

// *** testbench/far_side_model.sv ***
// Behavioural cores, DMA engines, domain units and peripherals facing the controller.
`timescale 1ns/1ps
module far_side_model #(parameter int NCPU = 2, NDMA = 2, NPER = 8, NDOM = 4) (
   // Commands from the bench
   input wire logic [2*NCPU-1:0] cpu_cmd_i,
   input wire logic [1:0] dom_cmd_i,
   input wire logic [NPER-1:0] idle_cmd_i,
   input wire logic wake_cmd_i,
   // Levels to the controller
   output logic [2*NCPU-1:0] cpu_lvl_o,
   output logic [2*NDMA-1:0] dma_lvl_o,
   output logic [2*NDOM-1:0] dom_lvl_o,
   output logic [NPER-1:0] periph_idle_o,
   output logic wakeup_o
);
   assign cpu_lvl_o = cpu_cmd_i;
   // DMA engines sit in sleep, so the memory rule hangs on the cores alone.
   assign dma_lvl_o = {NDMA{pwr_pkg::LVL_SLEEP}};
   assign dom_lvl_o = {NDOM{dom_cmd_i}};
   assign periph_idle_o = idle_cmd_i;
   assign wakeup_o = wake_cmd_i;
endmodule

// *** testbench/tb_top.sv ***
// Self-checking bench for the system power state controller.
`timescale 1ns/1ps
module tb_top;
   logic clock_i = 0, sys_rst_i = 1, wb_cyc_i = 0, wb_we_i = 0, wake_c = 0, ce_c = 1;
   logic [7:0] wb_adr_i = '0, idle_c = 8'hff;
   logic [31:0] wb_dat_i = '0, rdat;
   logic [3:0] wb_sel_i = '0, cpu_c = 4'hf;
   logic [1:0] dom_c = 2'h3;
   int failures = 0, check_count = 0, cyc_cnt = 0;
   logic [3:0] exp_v [3:6] = '{4'he, 4'hc, 4'h4, 4'h4};
   logic [11:0] tmask [7] = '{12'h000, 12'h001, 12'h007, 12'h00f, 12'h0ff, 12'h7ff, 12'hfff};
   wire [31:0] wb_dat_o;
   wire wb_ack_o, core_clk_en_o, periph_clk_en_o, hf, xtal_en_o, cpu_dom_pwr_o, wake;
   wire nvm_pwr_off_o, nvm_standby_o, cache_retain_o;
   wire [3:0] dom_pg_o, sys_state_o, cpu_lvl, dma_lvl;
   wire [11:0] tcm_pwr_o;
   wire [7:0] dom_lvl, pidle;
   wire [3:0] slp_v = {core_clk_en_o, periph_clk_en_o, hf, nvm_standby_o};
   wire [3:0] deep_v = {hf, nvm_pwr_off_o, cache_retain_o, cpu_dom_pwr_o};
   far_side_model #(.NCPU(2)) far_u (.cpu_cmd_i(cpu_c), .dom_cmd_i(dom_c), .idle_cmd_i(idle_c),
      .wake_cmd_i(wake_c), .cpu_lvl_o(cpu_lvl), .dma_lvl_o(dma_lvl), .dom_lvl_o(dom_lvl),
      .periph_idle_o(pidle), .wakeup_o(wake));
   system_power_state_control #(.NCPU(2), .OSC_CYC(2), .PWR_CYC(2), .MEM_CYC(2)) dut_u (
      .clock_i, .sys_rst_i, .ce_i(ce_c), .wb_cyc_i, .wb_stb_i(wb_cyc_i), .wb_we_i, .wb_adr_i,
      .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .cpu_lvl_i(cpu_lvl), .dma_lvl_i(dma_lvl),
      .dom_lvl_i(dom_lvl), .periph_idle_i(pidle), .wakeup_i(wake), .core_clk_en_o,
      .periph_clk_en_o, .high_freq_rc_oscillator_en_o(hf), .low_freq_rc_oscillator_en_o(),
      .xtal_en_o, .timer_run_o(), .cpu_dom_pwr_o, .cpu_state_retain_o(), .dom_pg_o,
      .nvm_pwr_off_o, .nvm_standby_o, .cache_pwr_off_o(), .cache_retain_o, .tcm_pwr_o,
      .ssram_pwr_o(), .sys_state_o);
   always #2.5 clock_i = ~clock_i;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      wb_cyc_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hf;
      do @(posedge clock_i); while (wb_ack_o !== 1'b1);
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(rdat, e);
   endtask
   task automatic set(input logic [3:0] c, input logic [7:0] i, input logic w);
      @(posedge clock_i);
      cpu_c <= c;
      idle_c <= i;
      wake_c <= w;
      dom_c <= 2'h3;
   endtask
   task automatic wait_st(input logic [3:0] v);
      int n;
      n = 0;
      while (sys_state_o !== v && n < 60) begin
         @(negedge clock_i);
         n++;
      end
      chk(sys_state_o, v);
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   always @(posedge clock_i) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 3000) begin
         failures++;
         end_sim;
      end
   end
   initial begin
      int d;
      repeat (6) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      rd(pwr_pkg::REG_CTRL, 32'h2);
      rd(pwr_pkg::REG_MEMRET, 32'h26);
      rd(8'h10, 32'h0);
      wb(1'b1, pwr_pkg::REG_FORCE, 32'h1);
      repeat (3) @(negedge clock_i);
      chk(dom_pg_o, 4'h1);
      wb(1'b1, pwr_pkg::REG_FORCE, 32'h0);
      dom_c <= 2'h0;
      repeat (8) @(negedge clock_i);
      chk(dom_pg_o, 4'hf);
      set(4'he, 8'hff, 1'b0);
      repeat (8) @(negedge clock_i);
      chk(sys_state_o, 4'h0);
      @(posedge clock_i);
      ce_c <= 1'b0;
      set(4'ha, 8'hfe, 1'b0);
      repeat (8) @(negedge clock_i);
      chk(sys_state_o, 4'h0);
      @(posedge clock_i);
      ce_c <= 1'b1;
      wait_st(4'h1);
      chk(slp_v, 4'h7);
      set(4'ha, 8'hfe, 1'b1);
      wait_st(4'h0);
      set(4'ha, 8'hff, 1'b0);
      wait_st(4'h2);
      chk(slp_v, 4'h3);
      set(4'hf, 8'hff, 1'b1);
      wait_st(4'h0);
      for (int i = 0; i < 7; i++) begin
         d = 3 + i % 4;
         wb(1'b1, pwr_pkg::REG_MEMRET, 32'(i));
         wb(1'b1, pwr_pkg::REG_CTRL, 32'(d));
         set(4'h5, 8'hff, 1'b0);
         wait_st(4'(d));
         chk(deep_v, exp_v[d]);
         chk(tcm_pwr_o, d == 6 ? 12'h000 : tmask[i]);
         if (d > 4) chk(xtal_en_o, d == 5);
         set(4'h5, 8'hff, 1'b1);
         wait_st(4'h0);
         chk(core_clk_en_o, 1'b1);
      end
      chk(nvm_pwr_off_o, 1'b0);
      set(4'h0, 8'hff, 1'b1);
      repeat (8) @(negedge clock_i);
      chk(nvm_pwr_off_o, 1'b1);
      end_sim;
   end
endmodule
